// [core/fpiv_pkg.sv]
/*
  Shared constants, field positions, carrier structs and state codes for the
  fixed priority interrupt vectoring block.
  Assumes a single core clock domain and an 8-bit register port.
*/
package fpiv_pkg;

  // Number of request sources after the serial and timer 1 requests are merged.
  localparam int SRC_N = 5;

  // Register offsets on the register port.
  localparam logic [7:0] OFF_ENABLE = 8'ha8;
  localparam logic [7:0] OFF_PRIORITY = 8'hb8;
  localparam logic [7:0] OFF_STATUS = 8'hc8;
  localparam logic [7:0] OFF_MASK = 8'hc9;
  localparam logic [7:0] OFF_STATE = 8'hca;

  // Enable register field positions.
  localparam int EN_GLOBAL_BIT = 7;
  localparam int EN_SERTMR1_BIT = 4;
  localparam int EN_COUNTER_BIT = 3;
  localparam int EN_PIN1_BIT = 2;
  localparam int EN_TIMER0_BIT = 1;
  localparam int EN_PIN0_BIT = 0;

  // Writable bits and reset values.
  localparam logic [7:0] ENABLE_WR_MASK = 8'h9f;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [4:0] PRIORITY_RESET = 5'h00;
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam int STAT_WITHDRAW_BIT = 5;

  // Source indices, in fixed order from highest to lowest.
  localparam logic [2:0] SRC_PIN0 = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_PIN1 = 3'h2;
  localparam logic [2:0] SRC_COUNTER = 3'h3;
  localparam logic [2:0] SRC_SERTMR1 = 3'h4;

  // Program memory addresses taken up on reset and on each source.
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_PIN0 = 12'h003;
  localparam logic [11:0] VEC_TIMER0 = 12'h00b;
  localparam logic [11:0] VEC_PIN1 = 12'h013;
  localparam logic [11:0] VEC_COUNTER = 12'h01b;
  localparam logic [11:0] VEC_SERTMR1 = 12'h023;

  // Pin synchroniser reset value: pins idle high.
  localparam logic [1:0] SYNC_RESET = 2'h3;

  // One register port access.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fpiv_bus_req_t;

  // One request offered to the core.
  typedef struct packed {
    logic valid;
    logic level;
    logic [2:0] src;
    logic [11:0] vector;
  } fpiv_offer_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b10
  } fpiv_state_t;

  // Vector address of a source index.
  function automatic logic [11:0] vector_of(input logic [2:0] src);
    case (src)
      SRC_PIN0: vector_of = VEC_PIN0;
      SRC_TIMER0: vector_of = VEC_TIMER0;
      SRC_PIN1: vector_of = VEC_PIN1;
      SRC_COUNTER: vector_of = VEC_COUNTER;
      SRC_SERTMR1: vector_of = VEC_SERTMR1;
      default: vector_of = VEC_RESET;
    endcase
  endfunction

endpackage

// [core/fpiv_arb.sv]
/*
  Combinational two-level fixed order arbiter.
  Assumes pending requests are already gated by their enables and that the
  caller registers the result.
*/
`timescale 1ns/1ps
module fpiv_arb (
  // Gated requests and their priority level bits.
  input wire logic [4:0] pending,
  input wire logic [4:0] prio,
  // Levels currently being serviced by the core.
  input wire logic [1:0] in_service,
  // Chosen request.
  output fpiv_pkg::fpiv_offer_t win
);
  import fpiv_pkg::*;

  // Lowest index set wins, giving the fixed order within one level.
  function automatic logic [3:0] first_set(input logic [4:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  logic [3:0] hi_pick;
  logic [3:0] lo_pick;

  // Split the pending set by level and pick within each.
  assign hi_pick = first_set(pending & prio);
  assign lo_pick = first_set(pending & ~prio);

  // The high level preempts a serviced low level; nothing preempts the high level.
  always_comb begin
    win = '0;
    if (hi_pick[3] && !in_service[1]) begin
      win.valid = 1'b1;
      win.level = 1'b1;
      win.src = hi_pick[2:0];
    end else if (lo_pick[3] && in_service == 2'h0) begin
      win.valid = 1'b1;
      win.level = 1'b0;
      win.src = lo_pick[2:0];
    end
    win.vector = vector_of(win.src);
  end

endmodule

// [core/fpiv_ctrl.sv]
/*
  Fixed priority interrupt vectoring controller: enable, priority, status and
  mask registers, request gating, offer to the core and service tracking.
  Assumes the core acknowledges an offer with a one-cycle pulse on the core
  clock and signals the end of a service routine with a one-cycle pulse.
  Assumes the timer, counter and serial requests are levels on the core clock
  that stay up until the core takes them, and that the two pins are
  asynchronous, active low and level sensitive.
*/
// Decided for this implementation: the plain strobed port and the register addresses.
// Contract
// - After reset, fetch starts at program address zero.
// - Each accepted source redirects to its own fixed vector address.
// - Simultaneous requests are served in fixed order, pin 0 first.
// - Two priority levels; the high level wins and preempts the low.
// - With the global enable clear, no request is accepted.
// - Enable bit 4 gates serial/timer 1, bit 3 the counter array.
// - Enable bit 2 gates pin 1, bit 1 timer 0, bit 0 pin 0.
// - Serial and timer 1 requests merge into one lowest source.
`timescale 1ns/1ps
module fpiv_ctrl (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Register port.
  input fpiv_pkg::fpiv_bus_req_t bus_req,
  output logic [7:0] rdata_q,
  // Request sources; the pins are asynchronous and active low.
  input wire logic outside_pin0_request_n,
  input wire logic outside_pin1_request_n,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic serial_port_request,
  input wire logic counter_array_request,
  // Core handshake.
  input wire logic core_ack,
  input wire logic core_return,
  output fpiv_pkg::fpiv_offer_t offer_q,
  output logic [1:0] in_service_q,
  // Reset fetch address and its one-cycle start pulse.
  output logic [11:0] fetch_addr_q,
  output logic fetch_start_q,
  // Interrupt output for system software.
  output logic irq_q
);
  import fpiv_pkg::*;

  // Pin synchronisers.
  logic [1:0] pin0_sync_q;
  logic [1:0] pin1_sync_q;

  // Software visible registers and the next status value.
  logic [7:0] enable_q;
  logic [4:0] priority_q;
  logic [5:0] status_q;
  logic [5:0] status_d;
  logic [5:0] mask_q;

  // Offer and start-up state.
  logic fetch_done_q;
  fpiv_state_t state_q;

  // Request path, from raw flags to the chosen winner and its events.
  logic [4:0] flags;
  logic [4:0] pending;
  fpiv_offer_t win;
  logic [5:0] status_set;

  // Register port decode and handshake terms.
  logic wr_enable;
  logic wr_priority;
  logic wr_mask;
  logic rd_status;
  logic take;
  logic drop;

  // True when a strobe is high for the given register offset.
  function automatic logic port_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] off);
    return strobe && (addr == off);
  endfunction

  // Register port decode.
  assign wr_enable = port_hit(bus_req.wr, bus_req.addr, OFF_ENABLE);
  assign wr_priority = port_hit(bus_req.wr, bus_req.addr, OFF_PRIORITY);
  assign wr_mask = port_hit(bus_req.wr, bus_req.addr, OFF_MASK);
  assign rd_status = port_hit(bus_req.rd, bus_req.addr, OFF_STATUS);

  // Two flip-flops on each pin before anything looks at it.
  // They reset to the idle high level, so leaving reset never looks like a request.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin0_sync_q <= SYNC_RESET;
      pin1_sync_q <= SYNC_RESET;
    end else begin
      pin0_sync_q <= {pin0_sync_q[0], outside_pin0_request_n};
      pin1_sync_q <= {pin1_sync_q[0], outside_pin1_request_n};
    end
  end

  // Request flags in fixed order; serial and timer 1 share the last slot.
  // The merged slot cannot tell its two causes apart, so the service routine
  // must poll the serial and timer 1 flags itself.
  always_comb begin
    flags = '0;
    flags[SRC_PIN0] = !pin0_sync_q[1];
    flags[SRC_TIMER0] = timer0_overflow_flag;
    flags[SRC_PIN1] = !pin1_sync_q[1];
    flags[SRC_COUNTER] = counter_array_request;
    flags[SRC_SERTMR1] = serial_port_request | timer1_overflow_flag;
  end

  // Each flag is gated by its own enable and the global enable.
  // Clearing the global bit stops every source at once, while the per-source
  // bits keep their values for when it is set again.
  always_comb begin
    pending = '0;
    if (enable_q[EN_GLOBAL_BIT]) begin
      pending[SRC_PIN0] = flags[SRC_PIN0] & enable_q[EN_PIN0_BIT];
      pending[SRC_TIMER0] = flags[SRC_TIMER0] & enable_q[EN_TIMER0_BIT];
      pending[SRC_PIN1] = flags[SRC_PIN1] & enable_q[EN_PIN1_BIT];
      pending[SRC_COUNTER] = flags[SRC_COUNTER] & enable_q[EN_COUNTER_BIT];
      pending[SRC_SERTMR1] = flags[SRC_SERTMR1] & enable_q[EN_SERTMR1_BIT];
    end
  end

  // Level and fixed order resolution.
  // The arbiter is purely combinational; its result is registered in the offer.
  fpiv_arb u_arb (
    .pending(pending),
    .prio(priority_q),
    .in_service(in_service_q),
    .win(win)
  );

  // The core takes the offer only while the offer still stands.
  // An ack outside an offer is ignored, so a late ack cannot open a service
  // that nobody was offered.
  assign take = state_q == ST_OFFER && core_ack;

  // An offer is withdrawn when a better one appears or its source is gone,
  // so a late disable or a higher request never leaves a stale vector.
  // Each withdrawal sets status bit 5 so software can see lost offers.
  assign drop = state_q == ST_OFFER && !core_ack &&
                (!win.valid || win.src != offer_q.src || win.level != offer_q.level);

  // Enable register; the two unused bits are held at zero.
  // Masking on write means the unused bits can never hold a one.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_q <= ENABLE_RESET;
    end else if (wr_enable) begin
      enable_q <= bus_req.wdata & ENABLE_WR_MASK;
    end
  end

  // Priority level register, one bit per source.
  // A one puts that source in the high level. A change re-judges a standing
  // offer through the withdraw term rather than waiting for it to be taken.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      priority_q <= PRIORITY_RESET;
    end else if (wr_priority) begin
      priority_q <= bus_req.wdata[4:0];
    end
  end

  // Mask register, same layout as status.
  // Only the interrupt output looks at it; the offer to the core ignores it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_q <= MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= bus_req.wdata[5:0];
    end
  end

  // Events: one bit per accepted source, plus a withdrawn offer.
  // Only one source can be taken in a cycle, and a take and a withdrawal never
  // fall in one cycle, since a withdrawal needs the ack low.
  always_comb begin
    status_set = '0;
    if (take) begin
      status_set[offer_q.src] = 1'b1;
    end
    status_set[STAT_WITHDRAW_BIT] = drop;
  end

  // A read clears the status, but an event in the same cycle survives it.
  // Letting the clear win here would lose that interrupt for good.
  always_comb begin
    status_d = rd_status ? status_set : (status_q | status_set);
  end

  // Status register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Level output, registered from the next status value so that it rises and
  // falls on the same edge as the status bits; the price is a longer path from
  // the register port into this flip-flop.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q);
    end
  end

  // Offer state machine: latch the winner, hold it until taken or withdrawn.
  // After a withdrawal the machine spends one cycle idle, which gives the
  // arbiter a settled view before the next offer.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (win.valid) begin
            state_q <= ST_OFFER;
          end
        end
        ST_OFFER: begin
          if (take || drop) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Offered request; the vector is fixed by the source.
  // Only valid is cleared on take, so the last source stays visible for reading.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      offer_q <= '0;
    end else if (state_q == ST_IDLE && win.valid) begin
      offer_q <= win;
    end else if (take || drop) begin
      offer_q.valid <= 1'b0;
    end
  end

  // Service tracking; a return ends the highest active level first.
  // With two levels a return always closes the most recent routine, since a
  // high routine may interrupt a low one but never the reverse.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_service_q <= 2'h0;
    end else begin
      logic [1:0] next;
      next = in_service_q;
      if (core_return) begin
        if (next[1]) begin
          next[1] = 1'b0;
        end else begin
          next[0] = 1'b0;
        end
      end
      if (take) begin
        next[offer_q.level] = 1'b1;
      end
      in_service_q <= next;
    end
  end

  // Fetch begins at the reset location, announced once after release.
  // The address is a constant; it sits in a flip-flop so that every output of
  // the block comes from one.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fetch_addr_q <= VEC_RESET;
      fetch_done_q <= 1'b0;
      fetch_start_q <= 1'b0;
    end else begin
      fetch_addr_q <= VEC_RESET;
      fetch_done_q <= 1'b1;
      fetch_start_q <= !fetch_done_q;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  // Returning zero outside the answer cycle lets several slaves share one read
  // bus through a plain OR.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        OFF_ENABLE: rdata_q <= enable_q & ENABLE_WR_MASK;
        OFF_PRIORITY: rdata_q <= {3'h0, priority_q};
        OFF_STATUS: rdata_q <= {2'h0, status_q};
        OFF_MASK: rdata_q <= {2'h0, mask_q};
        OFF_STATE: rdata_q <= {offer_q.valid, offer_q.level, offer_q.src,
                               in_service_q, state_q == ST_OFFER};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

endmodule

// [tb/fpiv_chk_sva.sv]
/* Assertion checker for the interrupt controller, watching its ports only.
   Assumes registers change only through bus_req writes, so a shadow copy is exact. */
`timescale 1ns/1ps
module fpiv_chk (
  // Clock, reset and register port.
  input wire logic mclk,
  input wire logic rst,
  input fpiv_pkg::fpiv_bus_req_t bus_req,
  input wire logic [7:0] rdata_q,
  // Requests and core side.
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic serial_port_request,
  input wire logic core_ack,
  input wire logic core_return,
  input fpiv_pkg::fpiv_offer_t offer_q,
  input wire logic [1:0] in_service_q,
  input wire logic [11:0] fetch_addr_q
);
  import fpiv_pkg::*;
  logic [7:0] en_q;
  logic [7:0] en_d_q;
  logic [4:0] pr_q;
  // Shadow registers; en_d_q is the enable that an offer just raised was decided on.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_q <= ENABLE_RESET;
      en_d_q <= ENABLE_RESET;
      pr_q <= PRIORITY_RESET;
    end else begin
      en_d_q <= en_q;
      if (bus_req.wr && bus_req.addr == OFF_ENABLE) en_q <= bus_req.wdata & ENABLE_WR_MASK;
      if (bus_req.wr && bus_req.addr == OFF_PRIORITY) pr_q <= bus_req.wdata[4:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    offer_q.valid && core_ack;
  endsequence
  sequence s_served;
    !offer_q.valid && in_service_q[$past(offer_q.level)];
  endsequence
  a_fetch_zero: assert property (fetch_addr_q == 12'h000)
    else $error("fetch address is not zero");
  a_vector_map: assert property (offer_q.valid |-> offer_q.src <= SRC_SERTMR1 &&
    offer_q.vector == {6'h00, offer_q.src, 3'h3}) else $error("offer vector wrong");
  a_order_fixed: assert property ($rose(offer_q.valid) && offer_q.src > SRC_TIMER0 &&
    $past(pr_q == 5'h00) |-> !$past(timer0_overflow_flag && en_q[7] && en_q[1]))
    else $error("lower source beat timer 0");
  a_high_blocks: assert property (in_service_q[1] && !core_return && !offer_q.valid
    |=> !offer_q.valid) else $error("offer during high level service");
  a_low_only: assert property ($rose(offer_q.valid) &&
    $past(in_service_q[0] && !core_return) |-> offer_q.level) else $error("low offer nested");
  a_global_off: assert property (!en_q[7] && !offer_q.valid |=> !offer_q.valid)
    else $error("offer with global enable clear");
  a_gate_bit: assert property ($rose(offer_q.valid) |-> en_d_q[7] &&
    en_d_q[offer_q.src]) else $error("offer from disabled source");
  a_merge_src: assert property ($rose(offer_q.valid) && offer_q.src == SRC_SERTMR1
    |-> $past(serial_port_request || timer1_overflow_flag)) else $error("merged source idle");
  a_take_serve: assert property (s_take |=> s_served)
    else $error("ack not served");
  a_read_enable: assert property (bus_req.rd && bus_req.addr == OFF_ENABLE |=>
    rdata_q == en_q) else $error("enable read back wrong");
endmodule
bind fpiv_ctrl fpiv_chk u_fpiv_chk (.mclk, .rst, .bus_req, .rdata_q, .timer0_overflow_flag,
  .timer1_overflow_flag, .serial_port_request, .core_ack, .core_return, .offer_q,
  .in_service_q, .fetch_addr_q);

// [tb/fpiv_core_model.sv]
/* Behavioural core: takes an offer after a set wait and ends each service later.
   Assumes the controller's clock and one offer at a time. */
`timescale 1ns/1ps
module fpiv_core_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Offer and how long to hesitate before taking it.
  input fpiv_pkg::fpiv_offer_t offer_q,
  input wire logic [3:0] ack_wait,
  // Handshake back to the controller.
  output logic core_ack,
  output logic core_return
);
  import fpiv_pkg::*;
  logic [3:0] wait_q;
  logic [3:0] svc_q;
  logic [1:0] depth_q;
  // A return never shares a cycle with an ack, which keeps the nesting count plain.
  // A service is counted only when the offer still stands in the ack cycle,
  // because a withdrawal can cancel the offer on the edge at which the ack rises.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {core_ack, core_return, wait_q, svc_q, depth_q} <= '0;
    end else begin
      core_ack <= 1'b0;
      core_return <= 1'b0;
      wait_q <= (offer_q.valid && !core_ack) ? wait_q + 4'h1 : 4'h0;
      if (core_ack && offer_q.valid) begin
        depth_q <= depth_q + 2'h1;
        svc_q <= 4'h0;
      end else if (offer_q.valid && !core_ack && wait_q >= ack_wait) begin
        core_ack <= 1'b1;
      end else if (depth_q != 2'h0) begin
        svc_q <= svc_q + 4'h1;
        if (svc_q == 4'hb) begin
          core_return <= 1'b1;
          depth_q <= depth_q - 2'h1;
          svc_q <= 4'h0;
        end
      end
    end
  end
endmodule

// [tb/fpiv_ctrl_tb.sv]
/* Self-checking bench for the interrupt controller with a core model beside it.
   Assumes the package, design and checker files are compiled before it. */
`timescale 1ns/1ps
module fpiv_ctrl_tb;
  import fpiv_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  fpiv_bus_req_t bus_req = '0;
  logic [4:0] src_m = 5'h00;
  logic use_t1 = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic [7:0] rdata_q;
  logic core_ack, core_return, fetch_start_q, irq_q, rd_seen;
  fpiv_offer_t offer_q;
  logic [1:0] in_service_q;
  logic [11:0] fetch_addr_q;
  logic [7:0] exp_rd[$];
  logic [11:0] exp_vec[$];
  logic [11:0] ord[2][5] = '{'{12'h003, 12'h00b, 12'h013, 12'h01b, 12'h023},
    '{12'h01b, 12'h023, 12'h003, 12'h00b, 12'h013}};
  int miscompares = 0;
  int cmp_count = 0;
  int seed_v;
  // Pins are active low, so the request mask is inverted for them.
  fpiv_ctrl u_fpiv_ctrl (.mclk, .rst, .bus_req, .rdata_q,
    .outside_pin0_request_n(~src_m[0]), .outside_pin1_request_n(~src_m[2]),
    .timer0_overflow_flag(src_m[1]), .timer1_overflow_flag(src_m[4] && use_t1),
    .serial_port_request(src_m[4] && !use_t1), .counter_array_request(src_m[3]),
    .core_ack, .core_return, .offer_q, .in_service_q, .fetch_addr_q, .fetch_start_q, .irq_q);
  fpiv_core_model u_fpiv_core_model (.mclk, .rst, .offer_q, .ack_wait, .core_ack,
    .core_return);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic cmp_val(input string what, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    cmp_val("read data", {4'h0, e}, {4'h0, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk) bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge mclk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk) bus_req <= '0;
  endtask
  // Waits until every noted vector was taken and all service has ended.
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((exp_vec.size() != 0 || in_service_q !== 2'b00) && n < 600);
    if (n >= 600) miscompares++;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Each read answer or taken offer is matched against the oldest note.
  always @(posedge mclk) begin
    if (rd_seen === 1'b1) cmp_rd(exp_rd.pop_front(), rdata_q);
    if (core_ack && offer_q.valid) begin
      cmp_val("vector", exp_vec.pop_front(), offer_q.vector);
      src_m <= src_m & ~(5'h01 << offer_q.src);
    end
    rd_seen = bus_req.rd;
  end
  // A hang counts as a mismatch; the budget is tens of times the expected run.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    seed_v = $urandom(87);
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    cmp_val("fetch start", 12'h001, {11'h000, fetch_start_q});
    cmp_val("fetch address", VEC_RESET, fetch_addr_q);
    rd(OFF_ENABLE, ENABLE_RESET);
    rd(8'h00, 8'h00);
    wr(OFF_ENABLE, 8'hff);
    rd(OFF_ENABLE, 8'h9f);
    wr(OFF_MASK, 8'h3f);
    wr(OFF_PRIORITY, 8'hff);
    rd(OFF_PRIORITY, 8'h1f);
    wr(OFF_PRIORITY, 8'h00);
    rd(OFF_MASK, 8'h3f);
    rd(OFF_STATE, 8'h00);
    $display("test registers done");
    // All sources up, one enabled: only that one may be taken.
    for (int s = 0; s < 6; s++) begin
      int k;
      k = (s > 4) ? 4 : s;
      ack_wait <= 4'($urandom_range(0, 6));
      use_t1 <= (s == 5);
      wr(OFF_ENABLE, 8'h80 | (8'h01 << k));
      exp_vec.push_back(ord[0][k]);
      src_m <= 5'h1f;
      settle();
    end
    src_m <= 5'h00;
    $display("test gating done");
    cmp_val("irq", 12'h001, {11'h000, irq_q});
    rd(OFF_STATUS, 8'h1f);
    repeat (3) @(posedge mclk);
    cmp_val("irq", 12'h000, {11'h000, irq_q});
    rd(OFF_STATUS, 8'h00);
    $display("test interrupt done");
    // Global enable off holds everything back; then the fixed and two-level orders.
    for (int p = 0; p < 2; p++) begin
      wr(OFF_ENABLE, 8'h1f & 8'($urandom));
      wr(OFF_PRIORITY, (p == 1) ? 8'h18 : 8'h00);
      src_m <= 5'h1f;
      repeat (20) @(posedge mclk);
      cmp_val("offer valid", 12'h000, {11'h000, offer_q.valid});
      for (int i = 0; i < 5; i++) exp_vec.push_back(ord[p][i]);
      wr(OFF_ENABLE, 8'h9f);
      settle();
      $display("test order %0d done", p);
    end
    // A standing low offer is withdrawn for a high one, then a high one nests.
    rd(OFF_STATUS, 8'h1f);
    ack_wait <= 4'hf;
    wr(OFF_PRIORITY, 8'h01);
    wr(OFF_ENABLE, 8'h83);
    src_m <= 5'h02;
    repeat (2) @(posedge mclk);
    rd(OFF_STATE, 8'h89);
    exp_vec.push_back(VEC_PIN0);
    exp_vec.push_back(VEC_TIMER0);
    src_m <= 5'h03;
    settle();
    ack_wait <= 4'h0;
    exp_vec.push_back(VEC_TIMER0);
    exp_vec.push_back(VEC_PIN0);
    src_m <= 5'h02;
    repeat (6) @(posedge mclk);
    src_m <= src_m | 5'h01;
    settle();
    rd(OFF_STATUS, 8'h23);
    $display("test withdraw done");
    wrap_up();
  end
endmodule
